// file: include/aec_seq_regs_pkg.sv
package aec_seq_regs_pkg;

    // ---------------------------------------------------------------
    // Register bus geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [8:0] SPARE_WORD_179_OFS = 9'h0b3;
    localparam logic [8:0] SPARE_WORD_180_OFS = 9'h0b4;
    localparam logic [8:0] SPARE_WORD_181_OFS = 9'h0b5;
    localparam logic [8:0] SAMPLED_COUNT_LOW_OFS = 9'h0b8;
    localparam logic [8:0] SAMPLED_COUNT_HIGH_OFS = 9'h0b9;
    localparam logic [8:0] MEAN_LEVEL_AND_LOCK_OFS = 9'h0ba;
    localparam logic [8:0] APPLIED_EXPOSURE_OFS = 9'h0bb;
    localparam logic [8:0] APPLIED_AMPLIFICATION_OFS = 9'h0bc;
    localparam logic [8:0] SPARE_WORD_189_OFS = 9'h0bd;
    localparam logic [8:0] SEQUENCER_SETUP_OFS = 9'h0c0;

    // ---------------------------------------------------------------
    // Values after reset
    // ---------------------------------------------------------------
    localparam logic [9:0] SPARE_WORD_179_RST = 10'h0aa;
    localparam logic [9:0] SPARE_WORD_180_RST = 10'h100;
    localparam logic [9:0] SPARE_WORD_181_RST = 10'h155;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [15:0] SEQUENCER_SETUP_RST = 16'h0000;

    // ---------------------------------------------------------------
    // Field widths and positions
    // ---------------------------------------------------------------
    localparam int SPARE_W = 10;
    localparam int COUNT_W = 19;
    localparam int COUNT_LOW_W = 16;
    localparam int MEAN_W = 10;
    localparam int LOCK_POS = 12;
    localparam int AMP_STEP_W = 2;
    localparam int AMP_STEP_A_POS = 0;
    localparam int AMP_STEP_B_POS = 2;
    localparam int DIGITAL_W = 12;
    localparam int DIGITAL_POS = 4;
    localparam int SEQ_ENABLE_POS = 0;
    localparam int SEQ_ROLLING_POS = 1;
    localparam int SEQ_TRIGGERED_POS = 4;
    localparam int SEQ_FOLLOWER_POS = 5;

endpackage : aec_seq_regs_pkg

// file: include/aec_status_if.sv
`timescale 1ns/1ps
interface aec_status_if;
    import aec_seq_regs_pkg::*;

    logic valid;
    logic [COUNT_W-1:0] count_in;
    logic [MEAN_W-1:0] mean_in;
    logic locked_in;
    logic [DATA_W-1:0] exposure_in;
    logic [DATA_W-1:0] amplification_in;
    logic [COUNT_W-1:0] count_held;
    logic [MEAN_W-1:0] mean_held;
    logic locked_held;
    logic [DATA_W-1:0] exposure_held;
    logic [DATA_W-1:0] amplification_held;

    modport regs (
        output valid, count_in, mean_in, locked_in, exposure_in,
        output amplification_in,
        input count_held, mean_held, locked_held, exposure_held,
        input amplification_held
    );

    modport holder (
        input valid, count_in, mean_in, locked_in, exposure_in,
        input amplification_in,
        output count_held, mean_held, locked_held, exposure_held,
        output amplification_held
    );

endinterface : aec_status_if

// file: sim/aec_seq_regs_chk.sv
`timescale 1ns/1ps
module aec_seq_regs_chk
    import aec_seq_regs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_wr_en,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic i_rd_en,
    input wire logic [DATA_W-1:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic i_stat_valid,
    input wire logic [COUNT_W-1:0] i_stat_count,
    input wire logic [MEAN_W-1:0] i_stat_mean,
    input wire logic i_stat_locked,
    input wire logic [DATA_W-1:0] i_stat_exposure,
    input wire logic o_seq_enable,
    input wire logic o_rolling_shutter,
    input wire logic o_triggered_mode,
    input wire logic o_follower_mode
);
    logic chk_q;
    logic [DATA_W-1:0] exp_q, mean_q, expo_q, wd_q;
    logic [COUNT_W-1:0] cnt_q;

    // Expected read word from the last status snapshot
    always_ff @(posedge i_clk) begin
        wd_q <= i_wr_data;
        if (i_ce) begin
            case (i_addr)
                SAMPLED_COUNT_LOW_OFS: exp_q <= cnt_q[15:0];
                SAMPLED_COUNT_HIGH_OFS: exp_q <= {13'h0, cnt_q[18:16]};
                MEAN_LEVEL_AND_LOCK_OFS: exp_q <= mean_q;
                default: exp_q <= expo_q;
            endcase
        end
        // Reset acts with or without clock enable, as in the design
        if (i_rst) begin
            chk_q <= 1'b0;
            cnt_q <= '0;
            mean_q <= '0;
            expo_q <= '0;
        end else if (i_ce) begin
            chk_q <= i_rd_en && i_addr >= SAMPLED_COUNT_LOW_OFS
                && i_addr <= APPLIED_EXPOSURE_OFS;
            if (i_stat_valid) begin
                cnt_q <= i_stat_count;
                mean_q <= {3'h0, i_stat_locked, 2'h0, i_stat_mean};
                expo_q <= i_stat_exposure;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_status_read: assert property (chk_q |-> o_rd_data == exp_q)
        else $error("status read word differs from snapshot");
    a_read_pulse: assert property (i_ce |=> o_rd_valid == $past(i_rd_en))
        else $error("read valid pulse wrong");
    a_setup_read: assert property (i_ce && i_rd_en && !i_wr_en
        && i_addr == SEQUENCER_SETUP_OFS |=> o_rd_data[3:0] ==
        {2'b00, o_rolling_shutter, o_seq_enable})
        else $error("setup readback differs from outputs");
    a_mode_write: assert property (i_ce && i_wr_en
        && i_addr == SEQUENCER_SETUP_OFS |=> o_seq_enable == wd_q[0]
        && o_rolling_shutter == wd_q[1]
        && o_triggered_mode == (wd_q[4] && !wd_q[1])
        && o_follower_mode == (wd_q[5] && !wd_q[1]))
        else $error("mode outputs do not follow write");
    a_rolling_gate: assert property (o_rolling_shutter |->
        !o_triggered_mode && !o_follower_mode)
        else $error("global shutter modes active while rolling");
    a_ce_freeze: assert property (!i_ce |=> $stable(o_rd_data)
        && $stable(o_seq_enable) && $stable(o_rd_valid))
        else $error("state moved with clock enable low");

    c_status_read: cover property (chk_q);
    c_read_update: cover property (i_ce && i_stat_valid && i_rd_en);
    c_triggered: cover property (o_triggered_mode);
endmodule : aec_seq_regs_chk

bind aec_seq_regs aec_seq_regs_chk i_aec_seq_regs_chk (.i_clk, .i_rst,
    .i_ce, .i_addr, .i_wr_en, .i_wr_data, .i_rd_en, .o_rd_data, .o_rd_valid,
    .i_stat_valid, .i_stat_count, .i_stat_mean, .i_stat_locked,
    .i_stat_exposure, .o_seq_enable, .o_rolling_shutter, .o_triggered_mode,
    .o_follower_mode);

// file: sim/aec_seq_regs_tb.sv
`timescale 1ns/1ps
module aec_seq_regs_tb;
    import aec_seq_regs_pkg::*;
    logic i_clk, i_rst, i_ce, i_wr_en, i_rd_en, i_stat_valid, i_stat_locked;
    logic [8:0] i_addr, a;
    logic [15:0] i_wr_data, o_rd_data, i_stat_exposure, r, seed;
    logic [18:0] i_stat_count, s_cnt;
    logic [9:0] i_stat_mean;
    logic [1:0] i_analog_amp_step_a, i_analog_amp_step_b;
    logic [11:0] i_stat_digital_amp;
    logic o_rd_valid, o_seq_enable, o_rolling_shutter;
    logic o_triggered_mode, o_follower_mode;
    logic [15:0] s_mean, s_expo, s_amp;
    int miscompares = 0;
    int checked = 0;

    aec_seq_regs i_aec_seq_regs (.i_clk, .i_rst, .i_ce, .i_addr, .i_wr_en,
        .i_wr_data, .i_rd_en, .o_rd_data, .o_rd_valid, .i_stat_valid,
        .i_stat_count, .i_stat_mean, .i_stat_locked, .i_stat_exposure,
        .i_analog_amp_step_a, .i_analog_amp_step_b, .i_stat_digital_amp,
        .o_seq_enable, .o_rolling_shutter, .o_triggered_mode,
        .o_follower_mode);

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd

    function automatic logic [15:0] st_exp(input logic [8:0] ad);
        case (ad)
            SAMPLED_COUNT_LOW_OFS: return s_cnt[15:0];
            SAMPLED_COUNT_HIGH_OFS: return {13'h0, s_cnt[18:16]};
            MEAN_LEVEL_AND_LOCK_OFS: return s_mean;
            APPLIED_EXPOSURE_OFS: return s_expo;
            APPLIED_AMPLIFICATION_OFS: return s_amp;
            default: return 16'h0000;
        endcase
    endfunction : st_exp

    task automatic chk(input string n, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [8:0] ad, input logic [15:0] d);
        @(negedge i_clk);
        i_addr = ad;
        i_wr_data = d;
        i_wr_en = 1'b1;
        @(negedge i_clk);
        i_wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] ad, input logic [15:0] e);
        @(negedge i_clk);
        i_addr = ad;
        i_rd_en = 1'b1;
        @(negedge i_clk);
        i_rd_en = 1'b0;
        chk("rd_valid", {15'h0, o_rd_valid}, 16'h0001);
        chk("rd_data", o_rd_data, e);
    endtask : rd

    // Loop update; m forces bits high, same reads the low count at once
    task automatic upd(input logic [15:0] m, input logic same);
        @(negedge i_clk);
        r = rnd() | m;
        i_stat_count = {r[2:0], rnd() | m};
        r = rnd() | m;
        i_stat_mean = r[9:0];
        i_stat_locked = r[12];
        i_stat_exposure = rnd() | m;
        r = rnd() | m;
        {i_stat_digital_amp, i_analog_amp_step_b, i_analog_amp_step_a} = r;
        i_stat_valid = 1'b1;
        i_addr = SAMPLED_COUNT_LOW_OFS;
        i_rd_en = same;
        @(negedge i_clk);
        i_stat_valid = 1'b0;
        i_rd_en = 1'b0;
        if (same) chk("same_cycle", o_rd_data, s_cnt[15:0]);
        s_cnt = i_stat_count;
        s_mean = {3'h0, i_stat_locked, 2'h0, i_stat_mean};
        s_expo = i_stat_exposure;
        s_amp = r;
    endtask : upd

    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial begin
        repeat (4000) @(posedge i_clk);
        miscompares++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {i_wr_en, i_rd_en, i_stat_valid, i_stat_locked, i_addr} = '0;
        {i_wr_data, i_stat_exposure, i_stat_count, i_stat_mean} = '0;
        {i_analog_amp_step_a, i_analog_amp_step_b, i_stat_digital_amp} = '0;
        {s_cnt, s_mean, s_expo, s_amp} = '0;
        seed = 16'hf096;
        i_ce = 1'b1;
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        rd(SPARE_WORD_179_OFS, 16'h00aa);
        rd(SPARE_WORD_180_OFS, 16'h0100);
        rd(SPARE_WORD_181_OFS, 16'h0155);
        rd(9'h1ff, 16'h0000);
        rd(SEQUENCER_SETUP_OFS, 16'h0000);
        for (a = 9'h0b3; a <= 9'h0b5; a++) begin
            r = rnd();
            wr(a, r);
            rd(a, {6'h00, r[9:0]});
        end
        for (int i = 0; i < 12; i++) begin
            upd(i == 0 ? 16'hffff : 16'h0000, i == 5);
            for (a = 9'h0b8; a <= 9'h0bd; a++) begin
                wr(a, rnd());
                rd(a, st_exp(a));
            end
        end
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            {r[5], r[4], r[1], r[0]} = i[3:0];
            wr(SEQUENCER_SETUP_OFS, r);
            chk("modes", {12'h000, o_follower_mode, o_triggered_mode,
                o_rolling_shutter, o_seq_enable},
                {12'h000, r[5] & ~r[1], r[4] & ~r[1], r[1], r[0]});
            rd(SEQUENCER_SETUP_OFS, r & 16'h0033);
        end
        @(negedge i_clk);
        i_ce = 1'b0;
        wr(SEQUENCER_SETUP_OFS, ~r);
        i_ce = 1'b1;
        chk("frozen", {12'h000, o_follower_mode, o_triggered_mode,
            o_rolling_shutter, o_seq_enable},
            {12'h000, r[5] & ~r[1], r[4] & ~r[1], r[1], r[0]});
        rd(SEQUENCER_SETUP_OFS, r & 16'h0033);
        // Mid-run reset: modes, status and spare word 180 back to reset
        @(negedge i_clk);
        i_rst = 1'b1;
        @(negedge i_clk);
        i_rst = 1'b0;
        {s_cnt, s_mean, s_expo, s_amp} = '0;
        chk("rst_modes", {12'h000, o_follower_mode, o_triggered_mode,
            o_rolling_shutter, o_seq_enable}, 16'h0000);
        for (a = 9'h0b8; a <= 9'h0bc; a++) begin
            rd(a, st_exp(a));
        end
        rd(SPARE_WORD_180_OFS, 16'h0100);
        results();
    end
endmodule : aec_seq_regs_tb

// file: verilog/aec_seq_regs.sv
// Summary of operation
// - 19-bit sampled count split over two words
// - Mean level bits 9:0, lock flag bit 12
// - Applied exposure word and amplification fields
// - Bit0 runs sequencer, bit1 selects rolling shutter
// - Bits 4,5 trigger/follower, global shutter only
`timescale 1ns/1ps
module aec_seq_regs
    import aec_seq_regs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_wr_en,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic i_rd_en,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_rd_valid,
    input wire logic i_stat_valid,
    input wire logic [COUNT_W-1:0] i_stat_count,
    input wire logic [MEAN_W-1:0] i_stat_mean,
    input wire logic i_stat_locked,
    input wire logic [DATA_W-1:0] i_stat_exposure,
    input wire logic [AMP_STEP_W-1:0] i_analog_amp_step_a,
    input wire logic [AMP_STEP_W-1:0] i_analog_amp_step_b,
    input wire logic [DIGITAL_W-1:0] i_stat_digital_amp,
    output logic o_seq_enable,
    output logic o_rolling_shutter,
    output logic o_triggered_mode,
    output logic o_follower_mode
);

    // ---------------------------------------------------------------
    // Status capture
    // ---------------------------------------------------------------
    aec_status_if st ();

    assign st.valid = i_stat_valid;
    assign st.count_in = i_stat_count;
    assign st.mean_in = i_stat_mean;
    assign st.locked_in = i_stat_locked;
    assign st.exposure_in = i_stat_exposure;
    assign st.amplification_in = {i_stat_digital_amp, i_analog_amp_step_b,
                                  i_analog_amp_step_a};

    aec_status_hold u_hold (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_ce (i_ce),
        .st (st.holder)
    );

    // ---------------------------------------------------------------
    // Status word assembly
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] count_low_word;
    logic [DATA_W-1:0] count_high_word;
    logic [DATA_W-1:0] mean_lock_word;
    logic [DATA_W-1:0] exposure_word;
    logic [DATA_W-1:0] amp_word;

    always_comb begin
        count_low_word = st.count_held[COUNT_LOW_W-1:0];
        count_high_word = '0;
        count_high_word[COUNT_W-COUNT_LOW_W-1:0] =
            st.count_held[COUNT_W-1:COUNT_LOW_W];
        mean_lock_word = '0;
        mean_lock_word[MEAN_W-1:0] = st.mean_held;
        mean_lock_word[LOCK_POS] = st.locked_held;
        exposure_word = st.exposure_held;
        amp_word = '0;
        amp_word[AMP_STEP_A_POS +: AMP_STEP_W] =
            st.amplification_held[AMP_STEP_A_POS +: AMP_STEP_W];
        amp_word[AMP_STEP_B_POS +: AMP_STEP_W] =
            st.amplification_held[AMP_STEP_B_POS +: AMP_STEP_W];
        amp_word[DIGITAL_POS +: DIGITAL_W] =
            st.amplification_held[DIGITAL_POS +: DIGITAL_W];
    end

    // ---------------------------------------------------------------
    // Writable registers
    // ---------------------------------------------------------------
    logic [SPARE_W-1:0] spare179_q, spare179_d;
    logic [SPARE_W-1:0] spare180_q, spare180_d;
    logic [SPARE_W-1:0] spare181_q, spare181_d;
    logic seq_enable_q, seq_enable_d;
    logic rolling_q, rolling_d;
    logic triggered_q, triggered_d;
    logic follower_q, follower_d;

    always_comb begin
        spare179_d = spare179_q;
        spare180_d = spare180_q;
        spare181_d = spare181_q;
        seq_enable_d = seq_enable_q;
        rolling_d = rolling_q;
        triggered_d = triggered_q;
        follower_d = follower_q;
        if (i_wr_en) begin
            if (i_addr == SPARE_WORD_179_OFS) begin
                spare179_d = i_wr_data[SPARE_W-1:0];
            end else if (i_addr == SPARE_WORD_180_OFS) begin
                spare180_d = i_wr_data[SPARE_W-1:0];
            end else if (i_addr == SPARE_WORD_181_OFS) begin
                spare181_d = i_wr_data[SPARE_W-1:0];
            end else if (i_addr == SEQUENCER_SETUP_OFS) begin
                seq_enable_d = i_wr_data[SEQ_ENABLE_POS];
                rolling_d = i_wr_data[SEQ_ROLLING_POS];
                triggered_d = i_wr_data[SEQ_TRIGGERED_POS];
                follower_d = i_wr_data[SEQ_FOLLOWER_POS];
            end
            // Status words and spare_word_189 drop the write
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            spare179_q <= SPARE_WORD_179_RST;
            spare180_q <= SPARE_WORD_180_RST;
            spare181_q <= SPARE_WORD_181_RST;
            seq_enable_q <= SEQUENCER_SETUP_RST[SEQ_ENABLE_POS];
            rolling_q <= SEQUENCER_SETUP_RST[SEQ_ROLLING_POS];
            triggered_q <= SEQUENCER_SETUP_RST[SEQ_TRIGGERED_POS];
            follower_q <= SEQUENCER_SETUP_RST[SEQ_FOLLOWER_POS];
        end else if (i_ce) begin
            spare179_q <= spare179_d;
            spare180_q <= spare180_d;
            spare181_q <= spare181_d;
            seq_enable_q <= seq_enable_d;
            rolling_q <= rolling_d;
            triggered_q <= triggered_d;
            follower_q <= follower_d;
        end
    end

    // ---------------------------------------------------------------
    // Mode outputs
    // ---------------------------------------------------------------
    logic seq_enable_out_q, seq_enable_out_d;
    logic rolling_out_q, rolling_out_d;
    logic triggered_out_q, triggered_out_d;
    logic follower_out_q, follower_out_d;

    always_comb begin
        seq_enable_out_d = seq_enable_d;
        rolling_out_d = rolling_d;
        // Trigger and follower have no meaning in rolling shutter
        triggered_out_d = triggered_d & ~rolling_d;
        follower_out_d = follower_d & ~rolling_d;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            seq_enable_out_q <= 1'b0;
            rolling_out_q <= 1'b0;
            triggered_out_q <= 1'b0;
            follower_out_q <= 1'b0;
        end else if (i_ce) begin
            seq_enable_out_q <= seq_enable_out_d;
            rolling_out_q <= rolling_out_d;
            triggered_out_q <= triggered_out_d;
            follower_out_q <= follower_out_d;
        end
    end

    assign o_seq_enable = seq_enable_out_q;
    assign o_rolling_shutter = rolling_out_q;
    assign o_triggered_mode = triggered_out_q;
    assign o_follower_mode = follower_out_q;

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic [DATA_W-1:0] seq_word;

    always_comb begin
        seq_word = '0;
        seq_word[SEQ_ENABLE_POS] = seq_enable_q;
        seq_word[SEQ_ROLLING_POS] = rolling_q;
        seq_word[SEQ_TRIGGERED_POS] = triggered_q;
        seq_word[SEQ_FOLLOWER_POS] = follower_q;
    end

    always_comb begin
        rd_valid_d = i_rd_en;
        rd_data_d = rd_data_q;
        if (i_rd_en) begin
            // Reads are pure selects, nothing is cleared or advanced
            if (i_addr == SPARE_WORD_179_OFS) begin
                rd_data_d = {{(DATA_W-SPARE_W){1'b0}}, spare179_q};
            end else if (i_addr == SPARE_WORD_180_OFS) begin
                rd_data_d = {{(DATA_W-SPARE_W){1'b0}}, spare180_q};
            end else if (i_addr == SPARE_WORD_181_OFS) begin
                rd_data_d = {{(DATA_W-SPARE_W){1'b0}}, spare181_q};
            end else if (i_addr == SAMPLED_COUNT_LOW_OFS) begin
                rd_data_d = count_low_word;
            end else if (i_addr == SAMPLED_COUNT_HIGH_OFS) begin
                rd_data_d = count_high_word;
            end else if (i_addr == MEAN_LEVEL_AND_LOCK_OFS) begin
                rd_data_d = mean_lock_word;
            end else if (i_addr == APPLIED_EXPOSURE_OFS) begin
                rd_data_d = exposure_word;
            end else if (i_addr == APPLIED_AMPLIFICATION_OFS) begin
                rd_data_d = amp_word;
            end else if (i_addr == SEQUENCER_SETUP_OFS) begin
                rd_data_d = seq_word;
            end else begin
                // Unmapped addresses and spare_word_189 read as zero
                rd_data_d = '0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end else if (i_ce) begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign o_rd_data = rd_data_q;
    assign o_rd_valid = rd_valid_q;

endmodule : aec_seq_regs

// file: verilog/aec_status_hold.sv
`timescale 1ns/1ps
module aec_status_hold
    import aec_seq_regs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    aec_status_if.holder st
);

    // ---------------------------------------------------------------
    // Latest loop results
    // ---------------------------------------------------------------
    logic [COUNT_W-1:0] count_q, count_d;
    logic [MEAN_W-1:0] mean_q, mean_d;
    logic locked_q, locked_d;
    logic [DATA_W-1:0] exposure_q, exposure_d;
    logic [DATA_W-1:0] amp_q, amp_d;

    always_comb begin
        count_d = count_q;
        mean_d = mean_q;
        locked_d = locked_q;
        exposure_d = exposure_q;
        amp_d = amp_q;
        if (st.valid) begin
            count_d = st.count_in;
            mean_d = st.mean_in;
            locked_d = st.locked_in;
            exposure_d = st.exposure_in;
            amp_d = st.amplification_in;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count_q <= '0;
            mean_q <= '0;
            locked_q <= 1'b0;
            exposure_q <= STATUS_RST;
            amp_q <= STATUS_RST;
        end else if (i_ce) begin
            count_q <= count_d;
            mean_q <= mean_d;
            locked_q <= locked_d;
            exposure_q <= exposure_d;
            amp_q <= amp_d;
        end
    end

    assign st.count_held = count_q;
    assign st.mean_held = mean_q;
    assign st.locked_held = locked_q;
    assign st.exposure_held = exposure_q;
    assign st.amplification_held = amp_q;

endmodule : aec_status_hold
